// ===== ddc_defs.vh
// constants shared by the command decoder files
`ifndef DDC_DEFS_VH
`define DDC_DEFS_VH

// decoded command codes on cmd_code
`define DDC_CMD_NONE       4'h0
`define DDC_CMD_MRS        4'h1
`define DDC_CMD_REF        4'h2
`define DDC_CMD_SRE        4'h3
`define DDC_CMD_SRX        4'h4
`define DDC_CMD_PRE        4'h5
`define DDC_CMD_PREA       4'h6
`define DDC_CMD_ACT        4'h7
`define DDC_CMD_WR         4'h8
`define DDC_CMD_RD         4'h9
`define DDC_CMD_NOP        4'hA
`define DDC_CMD_PDE        4'hB
`define DDC_CMD_PDX        4'hC
`define DDC_CMD_ZQCL       4'hD
`define DDC_CMD_ZQCS       4'hE

// strobe patterns {ras_n, cas_n, we_n} with act_n high
`define DDC_SIG_MRS        3'h0
`define DDC_SIG_REF        3'h1
`define DDC_SIG_PRE        3'h2
`define DDC_SIG_RFU        3'h3
`define DDC_SIG_WR         3'h4
`define DDC_SIG_RD         3'h5
`define DDC_SIG_ZQ         3'h6
`define DDC_SIG_NOP        3'h7

// mode register select that holds the reference settings
`define DDC_MR_VREF        3'h6
// reference field positions in the opcode
`define DDC_VREF_EN_BIT    7
`define DDC_VREF_RANGE_BIT 6
`define DDC_VREF_VAL_HI    5
`define DDC_VREF_VAL_LO    0
// highest legal reference step: fifty steps, 0 to 49
`define DDC_VREF_STEP_MAX  6'h31

// address bits that carry burst chop and auto precharge
`define DDC_BC_BIT         12
`define DDC_AP_BIT         10

// link clock edges a burst occupies (eight beats, double rate)
`define DDC_BURST_CLKS     3'h4

// width of the sampled pin bundle
`define DDC_PIN_W          27

`endif

// ===== ddc_pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module ddc_pin_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // raw pins and filtered copy
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] s1_r;   // metastable stage, read only by s2_r
    reg [W-1:0] s2_r;   // second stage
    reg [W-1:0] s3_r;   // third stage
    reg [W-1:0] q_r;    // accepted value

    // a bit changes only once stages two and three agree
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
            q_r  <= {W{1'b0}};
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= (s2_r & s3_r) | (q_r & (s2_r ^ s3_r));
        end
    end

    assign q = q_r;

endmodule // ddc_pin_sync

`default_nettype wire

// ===== ddc_decoder.v
// command decoder: samples command pins on the link clock's rising edge
`timescale 1ns/10ps
`default_nettype none
`include "ddc_defs.vh"

// How it works
// - decode only cs, act, three strobes, cke, plus a10 to split pre/prea and zqcs/zqcl, and a12 for the otf chop
// - act low turns strobes into row bits
// - mode writes: bank bits pick register, address opcode
// - bit 17 reserved, never taken as opcode
// - bursts run whole, mode picks fixed or otf
// - otf: chop low gives four, ap precharges
// - self refresh exit taken synchronously here
// - odt ignored in decode, off from the second clk of self refresh
// - no refresh issued while powered down
// - reset low acts asynchronously
// - don't-care pins are ignored
// - reference value has fifty steps
// - range bit chooses between two reference ranges
// - deselect takes no command, work continues
// - undefined commands flagged illegal
module ddc_decoder (
    // system clock and asynchronous reset
    input  wire        clk,
    input  wire        reset_n,
    // link pins, asynchronous to clk
    input  wire        ck_pin,
    input  wire        cke,
    input  wire        cs_n,
    input  wire        act_n,
    input  wire        ras_n_a16,
    input  wire        cas_n_a15,
    input  wire        we_n_a14,
    input  wire        odt,
    input  wire        a17,
    input  wire [1:0]  bg,
    input  wire [1:0]  ba,
    input  wire [13:0] addr,
    // burst configuration
    input  wire        burst_otf_en,
    input  wire        burst_fixed_bc4,
    // decoded command
    output reg         cmd_valid_r,
    output reg  [3:0]  cmd_code_r,
    output reg         cmd_illegal_r,
    output reg  [1:0]  bank_group_r,
    output reg  [1:0]  bank_r,
    output reg  [17:0] row_addr_r,
    output reg  [13:0] col_or_op_r,
    output reg  [2:0]  mr_sel_r,
    output reg         burst_chop_r,
    output reg         auto_pre_r,
    output reg         refresh_go_r,
    // device state
    output reg         self_refresh_r,
    output reg         power_down_r,
    output reg         burst_busy_r,
    output reg         odt_active_r,
    // reference settings
    output reg         vref_cal_en_r,
    output reg         vref_range_r,
    output reg  [5:0]  vref_value_r,
    output reg         vref_step_bad_r
);

    ////////////////////////////////////////////////////////////////////
    // reset release and pin sampling

    reg  [1:0]               rst_sync_r;    // reset release chain
    wire                     rst_n;         // synchronised reset
    wire [`DDC_PIN_W-1:0]    pins;          // filtered pins

    // assert asynchronously, release through two flops
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    ddc_pin_sync #(
        .W (`DDC_PIN_W)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({ck_pin, cke, cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14,
                 odt, a17, bg, ba, addr}),
        .q     (pins)
    );

    // unpacked view; all pins pass the same filter so they line up
    wire        s_ck   = pins[26];
    wire        s_cke  = pins[25];
    wire        s_cs_n = pins[24];
    wire        s_act  = pins[23];
    wire [2:0]  s_sig  = pins[22:20];      // ras, cas, we
    wire        s_odt  = pins[19];
    wire        s_a17  = pins[18];
    wire [1:0]  s_bg   = pins[17:16];
    wire [1:0]  s_ba   = pins[15:14];
    wire [13:0] s_addr = pins[13:0];

    ////////////////////////////////////////////////////////////////////
    // link clock edge and cke history

    reg ck_d_r;     // previous filtered link clock
    reg cke_prev_r; // cke at the previous link edge
    wire ck_rise = s_ck & ~ck_d_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_d_r     <= 1'b0;
            cke_prev_r <= 1'b0;
        end else begin
            ck_d_r <= s_ck;
            if (ck_rise) begin
                cke_prev_r <= s_cke;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // device state, one-hot

    localparam [2:0] ST_ACTIVE = 3'h1;  // normal command state
    localparam [2:0] ST_PDOWN  = 3'h2;  // power-down
    localparam [2:0] ST_SREF   = 3'h4;  // self refresh

    reg [2:0]  state_r;
    reg [2:0]  state_nxt;
    reg [3:0]  code_nxt;   // command found this edge
    reg        ill_nxt;    // undefined combination seen
    reg        burst_nxt;  // chop decision for read or write

    // decode is fed by the pins, the previous cke, the state and the burst configuration inputs
    always @* begin
        state_nxt = state_r;
        code_nxt  = `DDC_CMD_NONE;
        ill_nxt   = 1'b0;
        burst_nxt = burst_fixed_bc4;
        if (burst_otf_en) begin
            burst_nxt = ~s_addr[`DDC_BC_BIT];
        end
        case (state_r)
            ST_SREF: begin
                // exit sensed on the clock edge; deselect or nop legal
                if (!cke_prev_r && s_cke) begin
                    if (s_cs_n || (!s_act && 1'b0) ||
                        (s_act && s_sig == `DDC_SIG_NOP)) begin
                        code_nxt  = `DDC_CMD_SRX;
                        state_nxt = ST_ACTIVE;
                    end else begin
                        ill_nxt = 1'b1;
                    end
                end
            end
            ST_PDOWN: begin
                // pins other than cke and cs are don't-care here
                if (s_cke) begin
                    if (s_cs_n) begin
                        code_nxt  = `DDC_CMD_PDX;
                        state_nxt = ST_ACTIVE;
                    end else begin
                        ill_nxt = 1'b1;
                    end
                end
            end
            ST_ACTIVE: begin
                if (!s_cke) begin
                    if (s_cs_n) begin
                        code_nxt  = `DDC_CMD_PDE;
                        state_nxt = ST_PDOWN;
                    end else if (s_act && s_sig == `DDC_SIG_REF) begin
                        code_nxt  = `DDC_CMD_SRE;
                        state_nxt = ST_SREF;
                    end else begin
                        ill_nxt = 1'b1;
                    end
                end else if (!s_cs_n) begin
                    // deselect leaves code at none
                    if (!s_act) begin
                        code_nxt = `DDC_CMD_ACT;
                    end else begin
                        case (s_sig)
                            `DDC_SIG_MRS: code_nxt = `DDC_CMD_MRS;
                            `DDC_SIG_REF: code_nxt = `DDC_CMD_REF;
                            `DDC_SIG_PRE: code_nxt = s_addr[`DDC_AP_BIT] ?
                                `DDC_CMD_PREA : `DDC_CMD_PRE;
                            `DDC_SIG_WR:  code_nxt = `DDC_CMD_WR;
                            `DDC_SIG_RD:  code_nxt = `DDC_CMD_RD;
                            `DDC_SIG_ZQ:  code_nxt = s_addr[`DDC_AP_BIT] ?
                                `DDC_CMD_ZQCL : `DDC_CMD_ZQCS;
                            `DDC_SIG_NOP: code_nxt = `DDC_CMD_NOP;
                            default:      ill_nxt  = 1'b1;
                        endcase
                    end
                end
            end
            default: begin
                state_nxt = ST_ACTIVE;
                ill_nxt   = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // registered command outputs, updated once per link edge

    reg [2:0] burst_cnt_r;  // link edges left in current burst
    wire      is_rw = (code_nxt == `DDC_CMD_WR) || (code_nxt == `DDC_CMD_RD);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r         <= ST_ACTIVE;
            cmd_valid_r     <= 1'b0;
            cmd_code_r      <= `DDC_CMD_NONE;
            cmd_illegal_r   <= 1'b0;
            bank_group_r    <= 2'h0;
            bank_r          <= 2'h0;
            row_addr_r      <= 18'h00000;
            col_or_op_r     <= 14'h0000;
            mr_sel_r        <= 3'h0;
            burst_chop_r    <= 1'b0;
            auto_pre_r      <= 1'b0;
            refresh_go_r    <= 1'b0;
            burst_cnt_r     <= 3'h0;
            burst_busy_r    <= 1'b0;
            self_refresh_r  <= 1'b0;
            power_down_r    <= 1'b0;
            odt_active_r    <= 1'b0;
            vref_cal_en_r   <= 1'b0;
            vref_range_r    <= 1'b0;
            vref_value_r    <= 6'h00;
            vref_step_bad_r <= 1'b0;
        end else begin
            // strobes last one clk cycle
            cmd_valid_r   <= 1'b0;
            cmd_illegal_r <= 1'b0;
            refresh_go_r  <= 1'b0;
            // odt has no say in decode and is dead from the second clk of self refresh
            odt_active_r  <= s_odt & ~self_refresh_r;
            if (ck_rise) begin
                state_r        <= state_nxt;
                self_refresh_r <= (state_nxt == ST_SREF);
                power_down_r   <= (state_nxt == ST_PDOWN);
                cmd_illegal_r  <= ill_nxt;
                // every read or write restarts the count, so a burst that
                // follows another back to back is tracked to its own end
                if (is_rw) begin
                    burst_cnt_r <= `DDC_BURST_CLKS - 3'h1;
                end else if (burst_cnt_r != 3'h0) begin
                    burst_cnt_r <= burst_cnt_r - 3'h1;
                end
                // busy over the command edge and the three edges after it
                burst_busy_r <= (is_rw || burst_cnt_r != 3'h0);
                if (code_nxt != `DDC_CMD_NONE) begin
                    cmd_valid_r  <= 1'b1;
                    cmd_code_r   <= code_nxt;
                    bank_group_r <= s_bg;
                    bank_r       <= s_ba;
                    col_or_op_r  <= s_addr;
                    row_addr_r   <= {s_a17, s_sig, s_addr};
                    mr_sel_r     <= {s_bg[0], s_ba};
                    burst_chop_r <= is_rw & burst_nxt;
                    auto_pre_r   <= is_rw & s_addr[`DDC_AP_BIT];
                end
                // refresh engine only runs from the active state
                if (code_nxt == `DDC_CMD_REF && state_r == ST_ACTIVE) begin
                    refresh_go_r <= 1'b1;
                end
                // opcode taken from a13..a0; bit 17 left out
                if (code_nxt == `DDC_CMD_MRS &&
                    {s_bg[0], s_ba} == `DDC_MR_VREF) begin
                    vref_cal_en_r   <= s_addr[`DDC_VREF_EN_BIT];
                    vref_range_r    <= s_addr[`DDC_VREF_RANGE_BIT];
                    vref_value_r    <= s_addr[`DDC_VREF_VAL_HI:`DDC_VREF_VAL_LO];
                    vref_step_bad_r <= (s_addr[`DDC_VREF_VAL_HI:`DDC_VREF_VAL_LO]
                                        > `DDC_VREF_STEP_MAX);
                end
            end
        end
    end

endmodule // ddc_decoder

`default_nettype wire

// ===== ddc_ctrl_model.sv
// controller model: drives the command pins and a link clock that runs only per command
`timescale 1ns/10ps
`default_nettype none
module ddc_ctrl_model (
    // system clock paces every pin change
    input  wire logic        clk,
    // link pins towards the decoder
    output var  logic        ck_pin,
    output var  logic        cke,
    output var  logic        cs_n,
    output var  logic        act_n,
    output var  logic        ras_n_a16,
    output var  logic        cas_n_a15,
    output var  logic        we_n_a14,
    output var  logic        a17,
    output var  logic [1:0]  bg,
    output var  logic [1:0]  ba,
    output var  logic [13:0] addr
);
    // idle: clock parked low, deselected, cke high
    initial begin
        {ck_pin, cke, cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14} = 7'h3F;
        {a17, bg, ba, addr} = 19'h0;
    end
    // one 8 clk link period around a single command, pins held 4 clk either side
    task automatic send(input logic k, input logic c, input logic a, input logic [2:0] s,
                        input logic x, input logic [1:0] g, input logic [1:0] b,
                        input logic [13:0] d);
        @(posedge clk);
        {cke, cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14} <= {k, c, a, s};
        {a17, bg, ba, addr} <= {x, g, b, d};
        repeat (4) @(posedge clk);
        ck_pin <= 1'b1;
        repeat (4) @(posedge clk);
        ck_pin <= 1'b0;
        repeat (4) @(posedge clk);
        // hold over: address pins no longer show the last value
        {a17, bg, ba, addr} <= ~{a17, bg, ba, addr};
    endtask
endmodule // ddc_ctrl_model
`default_nettype wire

// ===== ddc_decoder_chk.sv
// assertions on the command decoder outputs
`timescale 1ns/10ps
`default_nettype none
`include "ddc_defs.vh"
module ddc_decoder_chk (
    // clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // decoded command and state
    input wire logic       cmd_valid_r,
    input wire logic [3:0] cmd_code_r,
    input wire logic       cmd_illegal_r,
    input wire logic       refresh_go_r,
    input wire logic       self_refresh_r,
    input wire logic       power_down_r,
    input wire logic       burst_busy_r,
    input wire logic       odt_active_r,
    input wire logic [5:0] vref_value_r,
    input wire logic       vref_step_bad_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a read or write strobe
    wire rw_w = cmd_valid_r && (cmd_code_r == `DDC_CMD_RD || cmd_code_r == `DDC_CMD_WR);
    a_valid_one_clk: assert property (cmd_valid_r |=> !cmd_valid_r)
        else $error("command strobe longer than one clock");
    a_illegal_alone: assert property (cmd_illegal_r |-> !cmd_valid_r ##1 !cmd_illegal_r)
        else $error("illegal flag not a lone pulse");
    a_busy_from_rw: assert property ($rose(burst_busy_r) |-> rw_w)
        else $error("burst busy without read or write");
    a_busy_holds: assert property (rw_w |-> burst_busy_r [*8])
        else $error("burst cut short");
    a_refresh_cause: assert property (refresh_go_r |-> cmd_valid_r && !power_down_r &&
        cmd_code_r == `DDC_CMD_REF) else $error("refresh issued without active refresh");
    a_sr_follows: assert property (cmd_valid_r && (cmd_code_r == `DDC_CMD_SRE ||
        cmd_code_r == `DDC_CMD_SRX) |-> self_refresh_r == (cmd_code_r == `DDC_CMD_SRE))
        else $error("self refresh state wrong");
    a_pd_follows: assert property (cmd_valid_r && (cmd_code_r == `DDC_CMD_PDE ||
        cmd_code_r == `DDC_CMD_PDX) |-> power_down_r == (cmd_code_r == `DDC_CMD_PDE))
        else $error("power-down state wrong");
    a_odt_off_sr: assert property (self_refresh_r && $past(self_refresh_r) |-> !odt_active_r)
        else $error("termination active in self refresh");
    a_step_flag: assert property (vref_step_bad_r == (vref_value_r > `DDC_VREF_STEP_MAX))
        else $error("reference step flag wrong");
endmodule // ddc_decoder_chk
`default_nettype wire

// ===== tb_top.sv
// top testbench for the command decoder
`timescale 1ns/10ps
`default_nettype none
`include "ddc_defs.vh"
module tb_top;
    logic clk = 1'b0, reset_n = 1'b0, burst_otf_en = 1'b0, burst_fixed_bc4 = 1'b0, odt = 1'b0;
    logic ck_pin, cke, cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14, a17;
    logic [1:0] bg, ba, bank_group_r, bank_r;
    logic [13:0] addr, col_or_op_r;
    logic cmd_valid_r, cmd_illegal_r, burst_chop_r, auto_pre_r, refresh_go_r;
    logic self_refresh_r, power_down_r, burst_busy_r, odt_active_r;
    logic vref_cal_en_r, vref_range_r, vref_step_bad_r;
    logic [3:0] cmd_code_r;
    logic [17:0] row_addr_r;
    logic [2:0] mr_sel_r;
    logic [5:0] vref_value_r, v;
    logic [27:0] notes[$]; // {code, detail} per expected result
    logic [31:0] rn;
    logic [13:0] d;
    int checks = 0, fails = 0, i, n;
    ddc_decoder i_ddc_decoder (.*);
    ddc_ctrl_model i_ddc_ctrl_model (.*);
    // 25 MHz system clock
    always #20 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [27:0] exp, input logic [27:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // what the outputs say, in the layout of the notes
    function automatic logic [27:0] seen();
        if (cmd_illegal_r === 1'b1)
            return 28'hF000000;
        case (cmd_code_r)
            `DDC_CMD_ACT: return {cmd_code_r, 6'h0, row_addr_r};
            `DDC_CMD_MRS: return {cmd_code_r, 7'h0, mr_sel_r, col_or_op_r};
            `DDC_CMD_RD, `DDC_CMD_WR:
                return {cmd_code_r, 4'h0, bank_group_r, bank_r, burst_chop_r, auto_pre_r,
                    col_or_op_r};
            default: return {cmd_code_r, 21'h0, self_refresh_r, power_down_r, refresh_go_r};
        endcase
    endfunction
    // each result is compared with the oldest note; a result with no note is stray
    always @(posedge clk) begin
        if (cmd_valid_r === 1'b1 || cmd_illegal_r === 1'b1) begin
            if (notes.size() == 0)
                check("stray command", 28'h0, seen());
            else
                check("command", notes.pop_front(), seen());
        end
    end
    // notes the expectation, then lets the model send; code zero means no result
    task automatic cmd(input logic [27:0] exp, input logic k, input logic c, input logic a,
                       input logic [2:0] s, input logic x, input logic [1:0] g,
                       input logic [1:0] b, input logic [13:0] dd);
        if (exp[27:24] != 4'h0)
            notes.push_back(exp);
        odt <= 1'($urandom);
        i_ddc_ctrl_model.send(k, c, a, s, x, g, b, dd);
        repeat (4) @(posedge clk);
    endtask
    // control command with random don't-care pins when deselected
    task automatic ctl(input logic [27:0] exp, input logic k, input logic c, input logic [2:0] s);
        logic [31:0] r;
        r = $urandom;
        cmd(exp, k, c, c ? r[20] : 1'b1, c ? r[23:21] : s, r[24], r[26:25], r[28:27], r[13:0]);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk);
        check("run length", 28'h0, 28'h1);
        finish_test();
    end
    initial begin
        void'($urandom(32'h73428abc));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (12) @(posedge clk);
        for (i = 0; i < 3; i++) begin // reference writes, bit 17 set, last step out of range
            v = (i == 2) ? 6'h32 : 6'($urandom_range(49));
            d = {6'h0, 1'b1, i[0], v};
            cmd({`DDC_CMD_MRS, 7'h0, `DDC_MR_VREF, d}, 1, 0, 1, `DDC_SIG_MRS, 1, 2'h3, 2'h2, d);
            check("vref", {19'h0, 1'b1, i[0], v, 1'(i == 2)}, {19'h0, vref_cal_en_r,
                vref_range_r, vref_value_r, vref_step_bad_r});
        end
        rn = $urandom;
        cmd({`DDC_CMD_ACT, 6'h0, rn[17:0]}, 1, 0, 0, rn[16:14], rn[17], rn[19:18],
            rn[21:20], rn[13:0]);
        for (i = 0; i < 8; i++) begin // every burst mode, back to back, with and without ap
            rn = $urandom;
            burst_otf_en <= i[0];
            burst_fixed_bc4 <= i[1];
            d = {rn[13:11], i[2], rn[9:0]};
            cmd({rn[14] ? `DDC_CMD_WR : `DDC_CMD_RD, 4'h0, rn[18:15], i[0] ? ~d[12] : i[1],
                i[2], d}, 1, 0, 1, rn[14] ? `DDC_SIG_WR : `DDC_SIG_RD, rn[19], rn[18:17],
                rn[16:15], d);
        end
        for (i = 0; i < 4; i++) begin // precharge one or all, calibration short or long
            rn = $urandom;
            d = {rn[13:11], i[0], rn[9:0]};
            cmd({i[1] ? (i[0] ? `DDC_CMD_ZQCL : `DDC_CMD_ZQCS) : (i[0] ? `DDC_CMD_PREA :
                `DDC_CMD_PRE), 24'h0}, 1, 0, 1, i[1] ? `DDC_SIG_ZQ : `DDC_SIG_PRE, rn[14],
                rn[16:15], rn[18:17], d);
            // last burst owns four link edges: busy through three of these, gone at the fourth
            check("burst busy", 28'(i < 3), 28'(burst_busy_r));
        end
        ctl({`DDC_CMD_REF, 24'h1}, 1, 0, `DDC_SIG_REF);
        ctl(28'h0, 1, 1, 3'h0);
        ctl({4'hF, 24'h0}, 1, 0, `DDC_SIG_RFU);
        ctl({`DDC_CMD_PDE, 24'h2}, 0, 1, 3'h0);
        ctl({`DDC_CMD_PDX, 24'h0}, 1, 1, 3'h0);
        ctl({`DDC_CMD_SRE, 24'h4}, 0, 0, `DDC_SIG_REF);
        ctl({`DDC_CMD_SRX, 24'h0}, 1, 1, 3'h0);
        for (n = 0; n < 100 && notes.size() != 0; n++)
            @(posedge clk);
        check("pending notes", 28'h0, 28'(notes.size()));
        finish_test();
    end
endmodule // tb_top
bind ddc_decoder ddc_decoder_chk i_ddc_decoder_chk (.*);
`default_nettype wire
